// ===== verilog/pgp_pkg.sv
// pgp_pkg: constants, register map and carrier types for the three-pin gpio
// assumes a 32-bit axi4-lite register bus and a 20 MHz system clock
package pgp_pkg;
    localparam int NUM_PINS = 3;
    localparam int CLK_HZ = 20000000;
    // debounce time in milliseconds, as specified
    localparam int DEBOUNCE_MS = 30;
    localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
    // dedicated debounce oscillator is modelled as a tick divider
    localparam int DBOSC_DIV = 20;

    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_CFG1 = 8'h04;
    localparam logic [7:0] OFS_CFG2 = 8'h08;
    localparam logic [7:0] OFS_INT = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_CHG = 8'h14;

    // pin config fields
    localparam int B_DIR = 0;
    localparam int B_DI = 1;
    localparam int B_DRV = 2;
    localparam int B_DO = 3;
    localparam int B_DBEN = 4;
    localparam int B_ALT = 5;
    localparam logic [5:0] CFG_RST = 6'h01;
    // interrupt layout: rise events bits 0..2, fall events bits 3..5
    localparam int B_FALL = 3;
    localparam logic [5:0] MASK_RST = 6'h3F;
    // charger control fields
    localparam int B_SOFTWARE_INPUT_SUSPEND = 0;
    localparam int B_FUSM = 1;
    localparam logic [1:0] CHG_RST = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic alt;
        logic dben;
        logic dout;
        logic drv;
        logic dir;
    } pgp_cfg_s;

    typedef enum logic [1:0] {
        PGP_RD_IDLE = 2'b00,
        PGP_RD_RESP = 2'b01
    } pgp_rd_e;
endpackage : pgp_pkg

// ===== verilog/pgp_debounce.sv
// pgp_debounce: one-pin stability filter on aclk, timed by a slow tick
// assumes tick is a one-cycle pulse from the debounce oscillator divider
`timescale 1ns/10ps
module pgp_debounce #(
    parameter int TICKS = pgp_pkg::DEBOUNCE_CYC / pgp_pkg::DBOSC_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic din,
    output logic dout_ff
);
    logic [19:0] cnt_ff;
    logic [19:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (din == dout_ff) begin
            nxt_cnt = 20'h00000;
        end else if (tick) begin
            nxt_cnt = cnt_ff + 20'h00001;
        end
    end

    // level must hold stable for the whole interval before it passes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 20'h00000;
            dout_ff <= 1'b0;
        end else if (nxt_cnt >= 20'(TICKS)) begin
            cnt_ff <= 20'h00000;
            dout_ff <= din;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : pgp_debounce

// ===== verilog/pgp_gpio.sv
// pgp_gpio: three configurable pins with edge interrupts and alt functions
// assumes pins are synchronous to aclk; the pad resolves oe/out externally
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// RULE_01: direction bit clear makes the pin output, set makes it input
// RULE_02: drive type 1 gives push-pull, 0 gives open-drain low only
// RULE_03: input level status follows the pin even when it is output
// RULE_04: optional 30 ms debounce per pin; bypassed when disabled
// RULE_05: debounce timed from its own oscillator tick
// RULE_06: separate rising and falling edge events per pin
// RULE_07: rising event reaches interrupt only when its mask is 0
// RULE_08: falling event reaches interrupt only when its mask is 0
// RULE_09: readable alternate bit selects standard or alternate function
// RULE_10: pin 0 alternate is active-high forced suspend, gated by mask
// RULE_11: pin 1 alternate drives buck channel zero voltage scaling select
// RULE_12: pin 2 alternate high turns the charging path off
// RULE_13: input switch off by software suspend, else by unmasked pin 0
// RULE_14: interrupt output low while any unmasked flag is pending
// RULE_15: all interrupt masks are set after reset
// RULE_16: output drives its value bit; open-drain one releases the pin
// RULE_17: flags sticky until cleared; debounced level used when enabled
module pgp_gpio #(
    parameter int NPIN = pgp_pkg::NUM_PINS,
    parameter int DB_TICKS = pgp_pkg::DEBOUNCE_CYC / pgp_pkg::DBOSC_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] general_input,
    output logic [2:0] general_output,
    output logic [2:0] pin_oe,
    output logic interrupt_out_n,
    output logic input_switch_on,
    output logic dynamic_voltage_scaling,
    output logic charge_path_disconnect
);
    pgp_pkg::pgp_cfg_s cfg_ff [NPIN];
    logic [5:0] int_ff;
    logic [5:0] mask_ff;
    logic [1:0] chg_ff;
    logic [2:0] lvl_ff;
    logic [2:0] db_lvl;
    logic [2:0] edge_src;
    logic [2:0] prev_ff;
    logic arm_ff; // low for the first edge after reset: no history yet
    logic [5:0] ev;
    logic [4:0] osc_ff;
    logic osc_tick;
    logic [7:0] awaddr_ff;
    logic aw_hold_ff;
    logic [31:0] wdata_ff;
    logic w_hold_ff;
    logic wlane_ff;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [5:0] nxt_int;
    logic [5:0] w1c;
    pgp_pkg::pgp_rd_e rd_state_ff;

    function automatic logic [31:0] cfg_word(input pgp_pkg::pgp_cfg_s c,
                                             input logic di);
        logic [31:0] w;
        w = 32'h00000000;
        w[pgp_pkg::B_DIR] = c.dir;
        w[pgp_pkg::B_DI] = di; // RULE_03
        w[pgp_pkg::B_DRV] = c.drv;
        w[pgp_pkg::B_DO] = c.dout;
        w[pgp_pkg::B_DBEN] = c.dben;
        w[pgp_pkg::B_ALT] = c.alt; // RULE_09
        return w;
    endfunction : cfg_word

    // pad levels registered once; also the input status seen by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_ff <= 3'h0;
        end else begin
            lvl_ff <= general_input; // RULE_03
        end
    end

    // stand-in for the dedicated debounce oscillator: a free tick divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_ff <= 5'h00;
        end else if (osc_ff == 5'(pgp_pkg::DBOSC_DIV - 1)) begin
            osc_ff <= 5'h00; // RULE_05
        end else begin
            osc_ff <= osc_ff + 5'h01;
        end
    end
    assign osc_tick = (osc_ff == 5'(pgp_pkg::DBOSC_DIV - 1));
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            pgp_debounce #(.TICKS(DB_TICKS)) u_db (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(osc_tick),
                .din(lvl_ff[gi]),
                .dout_ff(db_lvl[gi])
            ); // RULE_04 RULE_05
            assign edge_src[gi] = cfg_ff[gi].dben ? db_lvl[gi]
                                                  : lvl_ff[gi]; // RULE_17
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ff <= 3'h0;
            arm_ff <= 1'b0;
        end else begin
            arm_ff <= 1'b1;
            prev_ff <= arm_ff ? edge_src : general_input;
        end
    end
    // edges only count in standard input mode
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ev[i] = edge_src[i] & ~prev_ff[i] & cfg_ff[i].dir
                    & ~cfg_ff[i].alt; // RULE_06
            ev[i + pgp_pkg::B_FALL] = ~edge_src[i] & prev_ff[i]
                    & cfg_ff[i].dir & ~cfg_ff[i].alt; // RULE_06
        end
    end
    // write channel: address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_hold_ff <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wlane_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wlane_ff <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_hold_ff <= 1'b0;
        end
    end
    assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready
                             && s_axi_awvalid;
            s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pgp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr > pgp_pkg::OFS_CHG || wr_addr[1:0] != 2'h0)
                           ? pgp_pkg::RESP_SLVERR : pgp_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // config registers; only lowest byte lane carries fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                cfg_ff[i] <= '{dir: pgp_pkg::CFG_RST[pgp_pkg::B_DIR],
                               default: 1'b0};
            end
        end else if (wr_go && wlane_ff) begin
            for (int i = 0; i < 3; i++) begin
                if (wr_addr == pgp_pkg::OFS_CFG0 + 8'(4 * i)) begin
                    cfg_ff[i].dir <= wr_data[pgp_pkg::B_DIR]; // RULE_01
                    cfg_ff[i].drv <= wr_data[pgp_pkg::B_DRV]; // RULE_02
                    cfg_ff[i].dout <= wr_data[pgp_pkg::B_DO]; // RULE_16
                    cfg_ff[i].dben <= wr_data[pgp_pkg::B_DBEN]; // RULE_04
                    cfg_ff[i].alt <= wr_data[pgp_pkg::B_ALT]; // RULE_09
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= pgp_pkg::MASK_RST; // RULE_15
            chg_ff <= pgp_pkg::CHG_RST;
        end else if (wr_go && wlane_ff) begin
            if (wr_addr == pgp_pkg::OFS_MASK) begin
                mask_ff <= wr_data[5:0];
            end
            if (wr_addr == pgp_pkg::OFS_CHG) begin
                chg_ff <= wr_data[1:0];
            end
        end
    end

    // write-one-to-clear, but a new event in the same cycle wins
    assign w1c = (wr_go && wlane_ff && wr_addr == pgp_pkg::OFS_INT)
                 ? wr_data[5:0] : 6'h00;
    assign nxt_int = (int_ff & ~w1c) | ev; // RULE_17
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_ff <= 6'h00;
        end else begin
            int_ff <= nxt_int;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~|(nxt_int
                                  & ~mask_ff); // RULE_07 RULE_08 RULE_14
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= pgp_pkg::PGP_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pgp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            case (rd_state_ff)
                pgp_pkg::PGP_RD_IDLE: begin
                    if (s_axi_arvalid && !s_axi_arready) begin
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid <= 1'b1;
                        rd_state_ff <= pgp_pkg::PGP_RD_RESP;
                        s_axi_rresp <= pgp_pkg::RESP_OKAY;
                        case (s_axi_araddr)
                            pgp_pkg::OFS_CFG0:
                                s_axi_rdata <= cfg_word(cfg_ff[0], lvl_ff[0]);
                            pgp_pkg::OFS_CFG1:
                                s_axi_rdata <= cfg_word(cfg_ff[1], lvl_ff[1]);
                            pgp_pkg::OFS_CFG2:
                                s_axi_rdata <= cfg_word(cfg_ff[2], lvl_ff[2]);
                            pgp_pkg::OFS_INT:
                                s_axi_rdata <= {26'h0000000, int_ff};
                            pgp_pkg::OFS_MASK:
                                s_axi_rdata <= {26'h0000000, mask_ff};
                            pgp_pkg::OFS_CHG:
                                s_axi_rdata <= {30'h00000000, chg_ff};
                            default: begin
                                s_axi_rdata <= 32'h00000000;
                                s_axi_rresp <= pgp_pkg::RESP_SLVERR;
                            end
                        endcase
                    end
                end
                pgp_pkg::PGP_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state_ff <= pgp_pkg::PGP_RD_IDLE;
                    end
                end
                default: rd_state_ff <= pgp_pkg::PGP_RD_IDLE;
            endcase
        end
    end

    // pad drivers: alternate mode forces the pin to input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            general_output <= 3'h0;
            pin_oe <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!cfg_ff[i].dir && !cfg_ff[i].alt) begin // RULE_01
                    if (cfg_ff[i].drv) begin
                        general_output[i] <= cfg_ff[i].dout; // RULE_02
                        pin_oe[i] <= 1'b1;
                    end else begin
                        general_output[i] <= 1'b0; // RULE_16
                        pin_oe[i] <= !cfg_ff[i].dout; // RULE_02
                    end
                end else begin
                    general_output[i] <= 1'b0;
                    pin_oe[i] <= 1'b0;
                end
            end
        end
    end

    // alternate functions act on the raw registered pin level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_switch_on <= 1'b1;
            dynamic_voltage_scaling <= 1'b0;
            charge_path_disconnect <= 1'b0;
        end else begin
            input_switch_on <= !chg_ff[pgp_pkg::B_SOFTWARE_INPUT_SUSPEND]
                && !(!chg_ff[pgp_pkg::B_FUSM] && cfg_ff[0].alt
                     && lvl_ff[0]); // RULE_10 RULE_13
            dynamic_voltage_scaling <= cfg_ff[1].alt && lvl_ff[1]; // RULE_11
            charge_path_disconnect <= cfg_ff[2].alt && lvl_ff[2]; // RULE_12
        end
    end

    rise_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[0] && !mask_ff[0] |=> !interrupt_out_n) // RULE_07
        else $error("unmasked rise event did not raise interrupt");
    fall_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[3] && !mask_ff[3] |=> !interrupt_out_n) // RULE_08
        else $error("unmasked fall event did not raise interrupt");
    mask_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (&mask_ff) |=> interrupt_out_n) // RULE_14
        else $error("interrupt asserted with all masks set");
    flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        int_ff[0] && !w1c[0] |=> int_ff[0]) // RULE_17
        else $error("flag dropped without clear");
    pp_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg_ff[0].dir && !cfg_ff[0].alt && cfg_ff[0].drv
        |=> pin_oe[0] && general_output[0] == $past(cfg_ff[0].dout)) // RULE_02
        else $error("push-pull output not driven");
    od_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg_ff[1].dir && !cfg_ff[1].alt && !cfg_ff[1].drv && cfg_ff[1].dout
        |=> !pin_oe[1]) // RULE_16
        else $error("open-drain one not released");
    input_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_ff[2].dir |=> !pin_oe[2]) // RULE_01
        else $error("input pin driven");
    suspend_a: assert property (@(posedge aclk) disable iff (!aresetn)
        chg_ff[pgp_pkg::B_SOFTWARE_INPUT_SUSPEND] |=> !input_switch_on) // RULE_13
        else $error("switch on while software suspend set");
    disq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_ff[2].alt && lvl_ff[2] |=> charge_path_disconnect) // RULE_12
        else $error("charge path not cut");
    rise_c: cover property (@(posedge aclk) ev[0] && !mask_ff[0]);
    fall_c: cover property (@(posedge aclk) ev[3]);
    clear_c: cover property (@(posedge aclk) w1c[0] && int_ff[0]);
    fus_c: cover property (@(posedge aclk) !input_switch_on
                           && !chg_ff[pgp_pkg::B_SOFTWARE_INPUT_SUSPEND]);
endmodule : pgp_gpio

// ===== tb/pgp_pad_model.sv
// pgp_pad_model: board side of the three pins, with a pull-up on each pin
// assumes the bench commands any external drive through ext_en/ext_val
`timescale 1ns/10ps
module pgp_pad_model (
    input wire logic [2:0] general_output,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] pin_level
);
    // a pin driven by neither side floats up through the pull-up, never holds its last value
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i])
                pin_level[i] = general_output[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else
                pin_level[i] = 1'b1;
        end
    end
endmodule : pgp_pad_model

// ===== tb/pgp_gpio_with_alternate_functions_test.sv
// pgp_gpio_with_alternate_functions_test: self-checking bench for pgp_gpio
// assumes the pad model closes the loop from pin drive back to pin level
`timescale 1ns/10ps
module pgp_gpio_with_alternate_functions_test;
    typedef struct packed {
        logic [5:0] cfg;
        logic oe;
        logic lvl;
    } pgp_row_s;
    typedef struct packed {
        logic [1:0] chg;
        logic pin;
        logic on;
    } pgp_sw_s;
    localparam int TMO = 20000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, d;
    logic [2:0] general_input, general_output, pin_oe;
    logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
    logic interrupt_out_n, input_switch_on;
    logic dynamic_voltage_scaling, charge_path_disconnect;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    pgp_row_s rows [5] = '{'{6'h0C, 1'b1, 1'b1}, '{6'h04, 1'b1, 1'b0},
        '{6'h00, 1'b1, 1'b0}, '{6'h08, 1'b0, 1'b1}, '{6'h01, 1'b0, 1'b1}};
    pgp_sw_s sws [6] = '{'{2'h0, 1'b0, 1'b1}, '{2'h0, 1'b1, 1'b0},
        '{2'h2, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0},
        '{2'h0, 1'b0, 1'b1}};

    pgp_gpio #(.DB_TICKS(5)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .general_input(general_input),
        .general_output(general_output), .pin_oe(pin_oe),
        .interrupt_out_n(interrupt_out_n), .input_switch_on(input_switch_on),
        .dynamic_voltage_scaling(dynamic_voltage_scaling),
        .charge_path_disconnect(charge_path_disconnect));

    pgp_pad_model pad_u (.general_output(general_output), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_level(general_input));

    always #25 aclk = ~aclk;

    task end_sim;
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // a hang counts as one mismatch and still ends through the verdict
    always @(posedge aclk) begin
        cyc++;
        if (cyc == TMO) begin
            n_fail++;
            end_sim();
        end
    end

    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge aclk);
    endtask : step

    // address and data go out together; each is dropped once it is taken
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                done = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                done = 1'b1;
                v = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask : rd

    task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
        rd(a, d, rs);
        chk(what, d, e);
    endtask : rdchk

    initial begin
        step(3);
        aresetn <= 1'b1;
        step(4);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h1);
        chk("switch", {31'h0, input_switch_on}, 32'h1);
        rdchk("mask", pgp_pkg::OFS_MASK, 32'h3F);
        rdchk("chg", pgp_pkg::OFS_CHG, 32'h2);
        rdchk("cfg0", pgp_pkg::OFS_CFG0, 32'h3);
        rd(8'h18, d, rs);
        chk("rresp", {30'h0, rs}, {30'h0, pgp_pkg::RESP_SLVERR});
        wr(8'h18, 32'h1, rs);
        chk("bresp", {30'h0, rs}, {30'h0, pgp_pkg::RESP_SLVERR});
        // a write without the lowest byte lane is answered but ignored
        s_axi_wstrb <= 4'hE;
        wr(pgp_pkg::OFS_MASK, 32'h0, rs);
        s_axi_wstrb <= 4'hF;
        chk("bresp", {30'h0, rs}, {30'h0, pgp_pkg::RESP_OKAY});
        rdchk("mask", pgp_pkg::OFS_MASK, 32'h3F);
        rd(8'h02, d, rs);
        chk("rresp", {30'h0, rs}, {30'h0, pgp_pkg::RESP_SLVERR});
        // output modes and input mode on every pin; level bit shows the pad as resolved
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 5; i++) begin
                wr(8'(p * 4), {26'h0, rows[i].cfg}, rs);
                step(4);
                chk("oe", 32'(pin_oe[p]), 32'(rows[i].oe));
                if (rows[i].oe)
                    chk("out", 32'(general_output[p]),
                        32'(rows[i].lvl));
                rdchk("cfg", 8'(p * 4),
                    {26'h0, rows[i].cfg | {4'h0, rows[i].lvl, 1'b0}});
            end
        end
        // fall on pin 0: flagged while masked, interrupt only once unmasked
        wr(pgp_pkg::OFS_INT, 32'h3F, rs);
        ext_en <= 3'h7;
        ext_val <= 3'h6;
        step(5);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h08);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h1);
        wr(pgp_pkg::OFS_MASK, 32'h37, rs);
        step(2);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h0);
        wr(pgp_pkg::OFS_INT, 32'h08, rs);
        step(2);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h1);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h0);
        wr(pgp_pkg::OFS_MASK, 32'h36, rs);
        ext_val <= 3'h7;
        step(5);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h01);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h0);
        wr(pgp_pkg::OFS_INT, 32'h01, rs);
        wr(pgp_pkg::OFS_MASK, 32'h3F, rs);
        // debounce on pin 0: a short glitch is swallowed, a held level lands
        wr(pgp_pkg::OFS_CFG0, 32'h11, rs);
        wr(pgp_pkg::OFS_INT, 32'h3F, rs);
        ext_val <= 3'h6;
        step(10);
        ext_val <= 3'h7;
        step(200);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h0);
        ext_val <= 3'h6;
        step(20);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h0);
        step(300);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h08);
        // suspend switch, first with pin 0 in standard mode
        wr(pgp_pkg::OFS_CFG0, 32'h01, rs);
        wr(pgp_pkg::OFS_CHG, 32'h0, rs);
        ext_val <= 3'h7;
        step(4);
        chk("switch", {31'h0, input_switch_on}, 32'h1);
        wr(pgp_pkg::OFS_CFG0, 32'h21, rs);
        rdchk("cfg0", pgp_pkg::OFS_CFG0, 32'h23);
        for (int i = 0; i < 6; i++) begin
            wr(pgp_pkg::OFS_CHG, {30'h0, sws[i].chg}, rs);
            ext_val[0] <= sws[i].pin;
            step(4);
            chk("switch", 32'(input_switch_on),
                32'(sws[i].on));
        end
        // pins 1 and 2 in alternate mode ignore their output settings
        wr(pgp_pkg::OFS_CFG1, 32'h2C, rs);
        wr(pgp_pkg::OFS_CFG2, 32'h2C, rs);
        for (int v = 1; v >= 0; v--) begin
            ext_val[2:1] <= {v[0], v[0]};
            step(4);
            chk("oe", {29'h0, pin_oe}, 32'h0);
            chk("dvs", {31'h0, dynamic_voltage_scaling}, v);
            chk("disc", {31'h0, charge_path_disconnect}, v);
        end
        // a second reset in mid-run restores the masked defaults; pins
        // sit high across it, which must not read back as a rising edge
        ext_val <= 3'h7;
        aresetn <= 1'b0;
        step(3);
        aresetn <= 1'b1;
        step(2);
        chk("irq_n", {31'h0, interrupt_out_n}, 32'h1);
        rdchk("mask", pgp_pkg::OFS_MASK, 32'h3F);
        rdchk("cfg1", pgp_pkg::OFS_CFG1, 32'h3);
        rdchk("flags", pgp_pkg::OFS_INT, 32'h0);
        end_sim();
    end
endmodule : pgp_gpio_with_alternate_functions_test
